// *** mpi_top.sv ***
// ---------------------------------------------------------------
// mpi_top: three latched ports, edge interrupts, analog edge flags,
// internal ram and a multiplexed external bus behind an apb slave
// assumes one 125 MHz clock; all pins arrive asynchronously
// ---------------------------------------------------------------
//
// Added by the designer: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`include "mpi_cfg.svh"

// Contract
// (RULE1) Port A has eight latched bits whose direction each comes from its direction register.
// (RULE2) Port B has eight latched bits whose direction each comes from its direction register.
// (RULE3) Port C has eight latched bits, each set to plain port or control use by its function register.
// (RULE4) A falling edge on the non-maskable input raises the non-maskable interrupt.
// (RULE5) A rising edge on the first external input raises a maskable interrupt and serves zero-cross sensing.
// (RULE6) The board ties the memory-size pins to match the attached external memory.
// (RULE7) Analog inputs 7 to 4 may act as edge inputs whose falling edge sets a test flag for software.
// (RULE8) Eight analog channels are routed to the converter, whose results are eight bits wide.
// (RULE9) An external clock goes to the first oscillator pin only.
// (RULE10) The 256-byte internal ram sits at FF00h through FFFFh.
// (RULE11) Three external and eight internal sources are arbitrated over six levels with six vectors.
// (RULE12) Addresses are sixteen bits wide and reach 64K bytes directly.
// (RULE13) The memory-size pins encode 00 as 4 KB, 01 as 16 KB and 11 as 64 KB.
// (RULE14) Port D carries the multiplexed low address and data of the external bus.
// (RULE15) All logic is held in reset while the reset pin is low and runs again once it is high; the pin synchronisers and the ram are not reset by the pin.
module mpi_top #(
  parameter int RAM_DEPTH = `MPI_RAM_DEPTH,
  parameter int XFER_CYC = `MPI_EB_CYC
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic reset_n_pin,
  input wire logic [15:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] port_a_pins,
  output mpi_pkg::mpi_drv_t port_a_drv,
  input wire logic [7:0] port_b_pins,
  output mpi_pkg::mpi_drv_t port_b_drv,
  input wire logic [7:0] port_c_pins,
  output mpi_pkg::mpi_drv_t port_c_drv,
  input wire logic [7:0] port_c_ctrl_out,
  input wire logic [7:0] port_c_ctrl_oe,
  input wire logic [7:0] port_d_pins,
  output mpi_pkg::mpi_drv_t port_d_drv,
  input wire logic nmi_in,
  input wire logic ext_irq1_in,
  input wire logic ext_irq2_in,
  input wire logic [7:0] internal_irq,
  input wire logic [7:0] analog_inputs,
  input wire logic [1:0] mem_size_pins,
  input wire logic [7:0] adc_result,
  output logic [2:0] adc_channel,
  output logic irq,
  output logic [15:0] irq_vector,
  output logic [7:0] ext_addr_hi,
  output logic ext_ale,
  output logic ext_rd_n,
  output logic ext_wr_n
);
  import mpi_pkg::*;

  logic rst;
  logic [34:0] lvl;
  logic [4:0] fall;
  logic [1:0] rise;
  logic [7:0] ram [RAM_DEPTH];
  logic [7:0] port_a_latch_reg;
  logic [7:0] port_b_latch_reg;
  logic [7:0] port_c_latch_reg;
  logic [7:0] port_c_function_reg;
  logic [`MPI_ST_W-1:0] stat_reg;
  logic [`MPI_ST_W-1:0] mask_reg;
  logic [`MPI_ST_W-1:0] pend;
  logic [`MPI_ST_W-1:0] stat_clr;
  logic [15:0] vec_next;
  logic [3:0] edge_en_reg;
  logic [3:0] test_flag_reg;
  logic [3:0] flag_clr;
  logic [15:0] ext_addr_reg;
  logic [7:0] ext_data_reg;
  logic [7:0] ext_rdata_reg;
  logic eb_rd_reg;
  logic eb_err_reg;
  logic [7:0] eb_cnt_reg;
  logic in_range;
  mpi_eb_state_t eb_state_reg;
  logic setup;
  logic wr;
  logic rd;
  logic [31:0] rd_data;
  logic rd_err;
  logic arm_ok;

  if (RAM_DEPTH != 256) begin : g_chk_ram
    $error("mpi_top: ram must fill FF00h to FFFFh exactly");
  end
  if (XFER_CYC < 3 || XFER_CYC > 256) begin : g_chk_xfer
    $error("mpi_top: XFER_CYC must be 3 to 256");
  end

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  // levels: {reset pin, size pins, port d, c, b, a}
  mpi_edge_sync #(.W(35), .FALL(1'b0)) u_lvl (
    .clk(sys_clk),
    .rst(srst),
    .ce(ce),
    .pin({reset_n_pin, mem_size_pins, port_d_pins, port_c_pins,
          port_b_pins, port_a_pins}),
    .level(lvl),
    .edge_pulse()
  );

  // trailing edges: {analog 7..4, non-maskable}
  mpi_edge_sync #(.W(5), .FALL(1'b1)) u_fall (
    .clk(sys_clk),
    .rst(srst),
    .ce(ce),
    .pin({analog_inputs[7:4], nmi_in}),
    .level(),
    .edge_pulse(fall)
  );

  // leading edges: {second, first external interrupt}
  mpi_edge_sync #(.W(2), .FALL(1'b0)) u_rise (
    .clk(sys_clk),
    .rst(srst),
    .ce(ce),
    .pin({ext_irq2_in, ext_irq1_in}),
    .level(),
    .edge_pulse(rise)
  );

  // reset pin is low until its sampled level says otherwise
  assign rst = srst | ~lvl[34]; // RULE15

  // ---------------------------------------------------------------
  // apb slave: zero wait states, data captured in setup
  // ---------------------------------------------------------------
  assign setup = psel & ~penable;
  assign wr = ce & psel & penable & pready & pwrite & ~pslverr;
  assign rd = ce & psel & penable & pready & ~pwrite & ~pslverr;

  // read mux and decode; writes to read-only words are ignored
  always_comb begin
    rd_data = 32'h0000_0000;
    rd_err = 1'b0;
    if (paddr >= `MPI_RAM_BASE) begin
      rd_data[7:0] = ram[paddr[7:0]]; // RULE10 RULE12
    end else if (paddr == `MPI_PA_DATA) begin
      rd_data[7:0] = port_a_latch_reg;
    end else if (paddr == `MPI_PA_DIR) begin
      rd_data[7:0] = port_a_drv.oe;
    end else if (paddr == `MPI_PB_DATA) begin
      rd_data[7:0] = port_b_latch_reg;
    end else if (paddr == `MPI_PB_DIR) begin
      rd_data[7:0] = port_b_drv.oe;
    end else if (paddr == `MPI_PC_DATA) begin
      rd_data[7:0] = port_c_latch_reg;
    end else if (paddr == `MPI_PC_FUNC) begin
      rd_data[7:0] = port_c_function_reg;
    end else if (paddr == `MPI_PIN_LVL) begin
      rd_data = lvl[31:0];
    end else if (paddr == `MPI_IRQ_STAT) begin
      rd_data[`MPI_ST_W-1:0] = stat_reg;
    end else if (paddr == `MPI_IRQ_MASK) begin
      rd_data[`MPI_ST_W-1:0] = mask_reg;
    end else if (paddr == `MPI_IRQ_VEC) begin
      rd_data[15:0] = irq_vector;
    end else if (paddr == `MPI_EDGE_EN) begin
      rd_data[3:0] = edge_en_reg;
    end else if (paddr == `MPI_TEST_FLAG) begin
      rd_data[3:0] = test_flag_reg;
    end else if (paddr == `MPI_ADC_SEL) begin
      rd_data[2:0] = adc_channel;
    end else if (paddr == `MPI_ADC_RES) begin
      rd_data[7:0] = adc_result; // RULE8
    end else if (paddr == `MPI_EXT_ADDR) begin
      rd_data[15:0] = ext_addr_reg;
    end else if (paddr == `MPI_EXT_DATA) begin
      rd_data[7:0] = ext_rdata_reg;
    end else if (paddr == `MPI_EXT_CTRL) begin
      rd_data[3:0] = {lvl[33:32], eb_err_reg,
                      eb_state_reg != EB_IDLE};
    end else begin
      rd_err = 1'b1;
    end
  end

  // pready rises in the access cycle, so every transfer is 2 cycles
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (ce) begin
      pready <= setup;
      if (setup) begin
        prdata <= pwrite ? 32'h0000_0000 : rd_data;
        pslverr <= rd_err;
      end
    end
  end

  // ram: data only, left uninitialised by reset
  always_ff @(posedge sys_clk) begin
    if (wr && paddr >= `MPI_RAM_BASE) begin
      ram[paddr[7:0]] <= pwdata[7:0]; // RULE10
    end
  end

  // ---------------------------------------------------------------
  // ports a, b, c
  // ---------------------------------------------------------------
  // latches reset high so a pin turned to output starts high
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      port_a_latch_reg <= `MPI_LATCH_RST;
      port_a_drv.out <= `MPI_LATCH_RST;
      port_a_drv.oe <= `MPI_ZERO8;
    end else if (ce) begin
      if (wr && paddr == `MPI_PA_DATA) begin
        port_a_latch_reg <= pwdata[7:0]; // RULE1
        port_a_drv.out <= pwdata[7:0];
      end
      if (wr && paddr == `MPI_PA_DIR) begin
        port_a_drv.oe <= pwdata[7:0]; // RULE1
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      port_b_latch_reg <= `MPI_LATCH_RST;
      port_b_drv.out <= `MPI_LATCH_RST;
      port_b_drv.oe <= `MPI_ZERO8;
    end else if (ce) begin
      if (wr && paddr == `MPI_PB_DATA) begin
        port_b_latch_reg <= pwdata[7:0]; // RULE2
        port_b_drv.out <= pwdata[7:0];
      end
      if (wr && paddr == `MPI_PB_DIR) begin
        port_b_drv.oe <= pwdata[7:0]; // RULE2
      end
    end
  end

  // port c: function bit 1 hands the pin to the control logic
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      port_c_latch_reg <= `MPI_LATCH_RST;
      port_c_function_reg <= `MPI_ZERO8;
      port_c_drv.out <= `MPI_LATCH_RST;
      port_c_drv.oe <= `MPI_ZERO8;
    end else if (ce) begin
      if (wr && paddr == `MPI_PC_DATA) begin
        port_c_latch_reg <= pwdata[7:0];
      end
      if (wr && paddr == `MPI_PC_FUNC) begin
        port_c_function_reg <= pwdata[7:0];
      end
      port_c_drv.out <= (port_c_function_reg & port_c_ctrl_out) |
                        (~port_c_function_reg & port_c_latch_reg); // RULE3
      port_c_drv.oe <= (port_c_function_reg & port_c_ctrl_oe) |
                       ~port_c_function_reg; // RULE3
    end
  end

  // converter channel select
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      adc_channel <= 3'h0;
    end else if (ce && wr && paddr == `MPI_ADC_SEL) begin
      adc_channel <= pwdata[2:0]; // RULE8
    end
  end

  // ---------------------------------------------------------------
  // interrupts and analog edge flags
  // ---------------------------------------------------------------
  // clear only what the read returned; a new event always survives
  assign stat_clr = (rd && paddr == `MPI_IRQ_STAT) ?
                    prdata[`MPI_ST_W-1:0] : '0;
  assign flag_clr = (rd && paddr == `MPI_TEST_FLAG) ? prdata[3:0] : 4'h0;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      stat_reg <= '0;
      mask_reg <= '0;
    end else if (ce) begin
      stat_reg <= (stat_reg & ~stat_clr) |
                  {internal_irq, rise, fall[0]}; // RULE4 RULE5 RULE11
      if (wr && paddr == `MPI_IRQ_MASK) begin
        mask_reg <= pwdata[`MPI_ST_W-1:0];
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      edge_en_reg <= 4'h0;
      test_flag_reg <= 4'h0;
    end else if (ce) begin
      test_flag_reg <= (test_flag_reg & ~flag_clr) |
                       (fall[4:1] & edge_en_reg); // RULE7
      if (wr && paddr == `MPI_EDGE_EN) begin
        edge_en_reg <= pwdata[3:0];
      end
    end
  end

  // the non-maskable bit ignores the mask
  assign pend = stat_reg & (mask_reg | `MPI_NMI_MASK); // RULE4

  // six fixed levels, level 0 first
  always_comb begin
    if (pend[0]) begin
      vec_next = `MPI_VEC_L0; // RULE11
    end else if (pend[1]) begin
      vec_next = `MPI_VEC_L1;
    end else if (pend[`MPI_ST_INT2]) begin
      vec_next = `MPI_VEC_L2;
    end else if (|pend[`MPI_L3_HI:`MPI_L3_LO]) begin
      vec_next = `MPI_VEC_L3;
    end else if (|pend[`MPI_L4_HI:`MPI_L4_LO]) begin
      vec_next = `MPI_VEC_L4;
    end else if (|pend[`MPI_L5_HI:`MPI_L5_LO]) begin
      vec_next = `MPI_VEC_L5;
    end else begin
      vec_next = `MPI_VEC_NONE;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      irq <= 1'b0;
      irq_vector <= `MPI_VEC_NONE;
    end else if (ce) begin
      irq <= |pend; // RULE11
      irq_vector <= vec_next;
    end
  end

  // ---------------------------------------------------------------
  // external bus on port d
  // ---------------------------------------------------------------
  // size pins are the board's promise; a code of 10 counts as 4 KB
  always_comb begin
    if (lvl[33:32] == `MPI_MODE_64K) begin
      in_range = 1'b1; // RULE13
    end else if (lvl[33:32] == `MPI_MODE_16K) begin
      in_range = ext_addr_reg <= `MPI_LIM_16K;
    end else begin
      in_range = ext_addr_reg <= `MPI_LIM_4K;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ext_addr_reg <= 16'h0000;
      ext_data_reg <= `MPI_ZERO8;
    end else if (ce) begin
      if (wr && paddr == `MPI_EXT_ADDR) begin
        ext_addr_reg <= pwdata[15:0]; // RULE12
      end
      if (wr && paddr == `MPI_EXT_DATA) begin
        ext_data_reg <= pwdata[7:0];
      end
    end
  end

  // read data is taken from the synchronised pins, hence XFER_CYC>=3
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      eb_state_reg <= EB_IDLE;
      eb_cnt_reg <= 8'h00;
      eb_rd_reg <= 1'b0;
      eb_err_reg <= 1'b0;
      ext_rdata_reg <= `MPI_ZERO8;
      ext_addr_hi <= `MPI_ZERO8;
      ext_ale <= 1'b0;
      ext_rd_n <= 1'b1;
      ext_wr_n <= 1'b1;
      port_d_drv.out <= `MPI_ZERO8;
      port_d_drv.oe <= `MPI_ZERO8;
    end else if (ce) begin
      case (eb_state_reg)
        EB_IDLE: begin
          if (wr && paddr == `MPI_EXT_CTRL && pwdata[`MPI_CT_GO]) begin
            eb_err_reg <= ~in_range;
            if (in_range) begin
              eb_state_reg <= EB_ADDR;
              eb_rd_reg <= pwdata[`MPI_CT_RD];
              ext_ale <= 1'b1;
              ext_addr_hi <= ext_addr_reg[15:8];
              port_d_drv.out <= ext_addr_reg[7:0]; // RULE14
              port_d_drv.oe <= `MPI_ONES8;
            end
          end
        end
        EB_ADDR: begin
          ext_ale <= 1'b0;
          eb_cnt_reg <= 8'(XFER_CYC - 1);
          eb_state_reg <= EB_XFER;
          if (eb_rd_reg) begin
            ext_rd_n <= 1'b0;
            port_d_drv.oe <= `MPI_ZERO8; // RULE14
          end else begin
            ext_wr_n <= 1'b0;
            port_d_drv.out <= ext_data_reg; // RULE14
          end
        end
        EB_XFER: begin
          if (eb_cnt_reg == 8'h00) begin
            ext_rd_n <= 1'b1;
            ext_wr_n <= 1'b1;
            port_d_drv.oe <= `MPI_ZERO8;
            eb_state_reg <= EB_IDLE;
            if (eb_rd_reg) begin
              ext_rdata_reg <= lvl[31:24];
            end
          end else begin
            eb_cnt_reg <= eb_cnt_reg - 8'h01;
          end
        end
        default: begin
          eb_state_reg <= EB_IDLE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  a_pa_dir_write: assert property ( // RULE1
    @(posedge sys_clk) disable iff (rst)
    (wr && paddr == `MPI_PA_DIR) |=> port_a_drv.oe == $past(pwdata[7:0]))
    else $error("port a direction not taken from write");

  a_pb_latch_out: assert property ( // RULE2
    @(posedge sys_clk) disable iff (rst)
    (wr && paddr == `MPI_PB_DATA) ##1 (ce && !wr) |=>
      port_b_drv.out == $past(pwdata[7:0], 2))
    else $error("port b latch lost its value");

  a_pc_plain_mode: assert property ( // RULE3
    @(posedge sys_clk) disable iff (rst)
    (ce && port_c_function_reg == 8'h00) |=>
      (port_c_drv.oe == 8'hFF && port_c_drv.out == $past(port_c_latch_reg)))
    else $error("port c plain mode not driving latch");

  a_nmi_fall_irq: assert property ( // RULE4
    @(posedge sys_clk) disable iff (rst)
    ($fell(nmi_in) && ce && arm_ok) ##1 ce ##1 ce |=>
      stat_reg[0] ##1
      ((irq && irq_vector == `MPI_VEC_L0) || !ce))
    else $error("falling nmi edge missed");

  a_int1_rise_set: assert property ( // RULE5
    @(posedge sys_clk) disable iff (rst)
    ($rose(ext_irq1_in) && ce && arm_ok) ##1 ce ##1 ce |=> stat_reg[1])
    else $error("rising edge on first interrupt input missed");

  a_an4_test_flag: assert property ( // RULE7
    @(posedge sys_clk) disable iff (rst)
    ($fell(analog_inputs[4]) && ce && edge_en_reg[0] && arm_ok) ##1
      (ce && edge_en_reg[0]) ##1 (ce && edge_en_reg[0]) |=>
      test_flag_reg[0])
    else $error("analog trailing edge did not set test flag");

  a_ram_write_hold: assert property ( // RULE10
    @(posedge sys_clk) disable iff (rst)
    (wr && paddr >= `MPI_RAM_BASE) |=>
      ram[$past(paddr[7:0])] == $past(pwdata[7:0]))
    else $error("ram write lost");

  a_irq_unmasked: assert property ( // RULE11
    @(posedge sys_clk) disable iff (rst)
    (ce && (stat_reg & mask_reg) == '0 && stat_reg[0] == 1'b0) |=> !irq)
    else $error("interrupt without unmasked source");

  a_bus_addr_phase: assert property ( // RULE14
    @(posedge sys_clk) disable iff (rst)
    (ce && eb_state_reg == EB_IDLE && wr && paddr == `MPI_EXT_CTRL &&
     pwdata[`MPI_CT_GO] && in_range) |=>
      (ext_ale && port_d_drv.oe == 8'hFF &&
       {ext_addr_hi, port_d_drv.out} == $past(ext_addr_reg))
      ##1 (!ext_ale && (ext_rd_n ^ ext_wr_n)))
    else $error("external address phase wrong");

  a_reset_pin_hold: assert property ( // RULE15
    @(posedge sys_clk)
    rst |=> (port_a_drv.oe == 8'h00 && !irq && !pready))
    else $error("reset did not clear outputs");

  // helper: edge detectors are past their reset hold-off
  assign arm_ok = u_fall.arm_reg[2] && u_rise.arm_reg[2];
endmodule

// *** mpi_cfg.svh ***
// ---------------------------------------------------------------
// mpi_cfg.svh: offsets, field positions and reset values of the
// port and interrupt block; included by the top, the edge synchroniser and the bench
// ---------------------------------------------------------------
`ifndef MPI_CFG_SVH
`define MPI_CFG_SVH

// apb register byte offsets
`define MPI_PA_DATA 16'h0000
`define MPI_PA_DIR 16'h0004
`define MPI_PB_DATA 16'h0008
`define MPI_PB_DIR 16'h000C
`define MPI_PC_DATA 16'h0010
`define MPI_PC_FUNC 16'h0014
`define MPI_PIN_LVL 16'h0018
`define MPI_IRQ_STAT 16'h001C
`define MPI_IRQ_MASK 16'h0020
`define MPI_IRQ_VEC 16'h0024
`define MPI_EDGE_EN 16'h0028
`define MPI_TEST_FLAG 16'h002C
`define MPI_ADC_SEL 16'h0030
`define MPI_ADC_RES 16'h0034
`define MPI_EXT_ADDR 16'h0038
`define MPI_EXT_DATA 16'h003C
`define MPI_EXT_CTRL 16'h0040
`define MPI_RAM_BASE 16'hFF00
`define MPI_RAM_DEPTH 256

// reset values
`define MPI_LATCH_RST 8'hFF
`define MPI_ZERO8 8'h00
`define MPI_ONES8 8'hFF

// interrupt status layout and priority groups
`define MPI_ST_W 11
`define MPI_NMI_MASK 11'h001
`define MPI_ST_INT2 2
`define MPI_L3_HI 4
`define MPI_L3_LO 3
`define MPI_L4_HI 7
`define MPI_L4_LO 5
`define MPI_L5_HI 10
`define MPI_L5_LO 8

// vector address per priority level
`define MPI_VEC_L0 16'h0004
`define MPI_VEC_L1 16'h0008
`define MPI_VEC_L2 16'h0010
`define MPI_VEC_L3 16'h0018
`define MPI_VEC_L4 16'h0020
`define MPI_VEC_L5 16'h0028
`define MPI_VEC_NONE 16'h0000

// external bus control bits and memory size codes
`define MPI_CT_GO 0
`define MPI_CT_RD 1
`define MPI_MODE_16K 2'b01
`define MPI_MODE_64K 2'b11
`define MPI_LIM_4K 16'h0FFF
`define MPI_LIM_16K 16'h3FFF
`define MPI_EB_CYC 4

`endif

// *** mpi_pkg.sv ***
// ---------------------------------------------------------------
// mpi_pkg: types shared by the port and interrupt block
// assumes nothing beyond a systemverilog compiler
// ---------------------------------------------------------------
package mpi_pkg;

  // one eight-bit two-way port: drive value and output enable
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
  } mpi_drv_t;

  // external memory cycle sequencer
  typedef enum logic [1:0] {
    EB_IDLE,
    EB_ADDR,
    EB_XFER
  } mpi_eb_state_t;

endpackage

// *** mpi_edge_sync.sv ***
// ---------------------------------------------------------------
// mpi_edge_sync: two-flop synchroniser with edge detect
// assumes pins are asynchronous to clk; edges held off after reset
// ---------------------------------------------------------------
`timescale 1ns/1ps
`include "mpi_cfg.svh"

module mpi_edge_sync #(
  parameter int W = 1,
  parameter bit FALL = 1'b0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [W-1:0] pin,
  output logic [W-1:0] level,
  output logic [W-1:0] edge_pulse
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] prev_reg;
  logic [2:0] arm_reg;

  if (W < 1) begin : g_chk
    $error("mpi_edge_sync: W must be at least 1");
  end

  // meta_reg feeds only level; prev_reg is one stage behind level
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_reg <= '0;
      level <= '0;
      prev_reg <= '0;
      arm_reg <= 3'h0;
    end else if (ce) begin
      meta_reg <= pin;
      level <= meta_reg;
      prev_reg <= level;
      arm_reg <= {arm_reg[1:0], 1'b1};
    end
  end

  // no edge until prev holds a real sample, so reset makes no event
  always_comb begin
    if (FALL) begin
      edge_pulse = prev_reg & ~level & {W{arm_reg[2]}};
    end else begin
      edge_pulse = level & ~prev_reg & {W{arm_reg[2]}};
    end
  end
endmodule

// *** mpi_far_side.sv ***
// printer-side model: sensors on ports a to c, memory on port d
// assumes registered drive structs and one system clock
`timescale 1ns/1ps
module mpi_far_side (
  input wire logic sys_clk,
  input wire mpi_pkg::mpi_drv_t pa,
  input wire mpi_pkg::mpi_drv_t pb,
  input wire mpi_pkg::mpi_drv_t pc,
  input wire mpi_pkg::mpi_drv_t pd,
  input wire logic [23:0] sense,
  input wire logic [7:0] addr_hi,
  input wire logic ale,
  input wire logic rd_n,
  output logic [7:0] pa_pin,
  output logic [7:0] pb_pin,
  output logic [7:0] pc_pin,
  output logic [7:0] pd_pin,
  input wire logic wr_n
);
  import mpi_pkg::*;
  logic [7:0] mem [0:65535];
  logic [7:0] lo = 8'h00;
  logic [7:0] idle = 8'h00;
  // sensors drive only the bits that the device leaves undriven
  assign pa_pin = (pa.out & pa.oe) | (sense[7:0] & ~pa.oe);
  assign pb_pin = (pb.out & pb.oe) | (sense[15:8] & ~pb.oe);
  assign pc_pin = (pc.out & pc.oe) | (sense[23:16] & ~pc.oe);
  // released bus shows a moving pattern so stale data cannot pass
  assign pd_pin = |pd.oe ? pd.out : (!rd_n ? mem[{addr_hi, lo}] : idle);
  // memory latches the low address on ale and stores on a write strobe
  always @(posedge sys_clk) begin
    idle <= idle + 8'h5B;
    if (ale) lo <= pd.out;
    if (!wr_n) mem[{addr_hi, lo}] <= pd.out;
  end
endmodule

// *** mcu_ports_and_interrupt_pins_tb.sv ***
// self-checking bench of mpi_top with a register model
// assumes the far-side model and a single 125 MHz clock
`timescale 1ns/1ps
`include "mpi_cfg.svh"
module mcu_ports_and_interrupt_pins_tb;
  import mpi_pkg::*;
  logic sys_clk = 0, srst = 1, ce = 1, reset_n_pin = 1;
  logic psel = 0, penable = 0, pwrite = 0, pready, pslverr, er;
  logic [15:0] paddr = 0, irq_vector;
  logic [31:0] pwdata = 0, prdata, rd, d;
  logic [7:0] port_a_pins, port_b_pins, port_c_pins, port_d_pins;
  mpi_drv_t port_a_drv, port_b_drv, port_c_drv, port_d_drv;
  logic [7:0] port_c_ctrl_out = 0, port_c_ctrl_oe = 0, internal_irq = 0;
  logic nmi_in = 1, ext_irq1_in = 0, ext_irq2_in = 0, irq, ext_ale;
  logic [7:0] analog_inputs = 8'hFF, adc_result = 0, ext_addr_hi;
  logic [1:0] mem_size_pins = 2'b00;
  logic [2:0] adc_channel;
  logic ext_rd_n, ext_wr_n;
  logic [23:0] sense = 0;
  int errors = 0, samples_checked = 0;
  logic [7:0] m [6];
  mpi_top #(.XFER_CYC(6)) u_dut (.sys_clk, .srst, .ce, .reset_n_pin,
    .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
    .port_a_pins, .port_a_drv, .port_b_pins, .port_b_drv, .port_c_pins,
    .port_c_drv, .port_c_ctrl_out, .port_c_ctrl_oe, .port_d_pins,
    .port_d_drv, .nmi_in, .ext_irq1_in, .ext_irq2_in, .internal_irq,
    .analog_inputs, .mem_size_pins, .adc_result, .adc_channel, .irq,
    .irq_vector, .ext_addr_hi, .ext_ale, .ext_rd_n, .ext_wr_n);
  mpi_far_side u_far (.sys_clk, .pa(port_a_drv), .pb(port_b_drv),
    .pc(port_c_drv), .pd(port_d_drv), .sense, .addr_hi(ext_addr_hi),
    .ale(ext_ale), .rd_n(ext_rd_n), .wr_n(ext_wr_n), .pa_pin(port_a_pins),
    .pb_pin(port_b_pins), .pc_pin(port_c_pins), .pd_pin(port_d_pins));
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  initial forever #4 sys_clk = ~sys_clk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // apb master: holds the request until pready is seen at an edge
  task automatic apb(input logic [15:0] a, input logic w, input logic [31:0] v);
    @(posedge sys_clk);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= v;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic bus_idle;
    do apb(`MPI_EXT_CTRL, 0, 0); while (rd[0] !== 1'b0);
  endtask
  task automatic stop_test;
    $display("checked %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // the tests take about 250 cycles; cut a hang well after that
  initial begin
    repeat (30000) @(posedge sys_clk);
    errors++;
    stop_test();
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(94));
    repeat (20) @(posedge sys_clk);
    srst <= 1'b0;
    repeat (5) @(posedge sys_clk);
    for (int i = 0; i < 6; i++) begin
      apb(16'(4 * i), 0, 0);
      chk(rd, i % 2 ? 0 : 32'hFF);
    end
    sense <= $urandom;
    port_c_ctrl_out <= $urandom;
    port_c_ctrl_oe <= $urandom;
    for (int i = 0; i < 6; i++) begin
      m[i] = 8'($urandom);
      apb(16'(4 * i), 1, m[i]);
      apb(16'(4 * i), 0, 0);
      chk(rd, m[i]);
    end
    repeat (6) @(posedge sys_clk);
    chk({port_a_drv, port_b_drv}, {m[0], m[1], m[2], m[3]});
    chk(port_c_drv, {(port_c_ctrl_out & m[5]) | (m[4] & ~m[5]),
      (port_c_ctrl_oe & m[5]) | ~m[5]});
    apb(`MPI_PIN_LVL, 0, 0);
    chk(rd[15:0], {(m[2] & m[3]) | (sense[15:8] & ~m[3]),
      (m[0] & m[1]) | (sense[7:0] & ~m[1])});
    apb(`MPI_PIN_LVL, 0, 0);
    chk(rd[23:0], {port_c_pins, port_b_pins, port_a_pins});
    apb(`MPI_IRQ_MASK, 1, 32'h7FF);
    for (int k = 0; k < 4; k++) begin
      @(posedge sys_clk);
      case (k)
        0: nmi_in <= 1'b0;
        1: ext_irq1_in <= 1'b1;
        2: ext_irq2_in <= 1'b1;
        default: internal_irq <= 8'h20;
      endcase
      @(posedge sys_clk);
      internal_irq <= 8'h00;
      repeat (6) @(posedge sys_clk);
      chk({irq, irq_vector}, {1'b1, k == 0 ? `MPI_VEC_L0 : k == 1 ?
        `MPI_VEC_L1 : k == 2 ? `MPI_VEC_L2 : `MPI_VEC_L5});
      apb(`MPI_IRQ_STAT, 0, 0);
      chk(rd, k < 3 ? 1 << k : 32'h100);
      apb(`MPI_IRQ_STAT, 0, 0);
      chk(rd, 0);
    end
    apb(`MPI_EDGE_EN, 1, 32'hF);
    analog_inputs <= 8'h67;
    repeat (6) @(posedge sys_clk);
    apb(`MPI_TEST_FLAG, 0, 0);
    chk(rd, 32'h9);
    adc_result <= $urandom;
    apb(`MPI_ADC_SEL, 1, 5);
    apb(`MPI_ADC_RES, 0, 0);
    chk({adc_channel, rd[28:0]}, {3'd5, 21'h0, adc_result});
    apb(16'h0100, 1, 5);
    apb(16'h0100, 0, 0);
    chk({er, rd[30:0]}, {1'b1, 31'h0});
    d = $urandom;
    apb(16'hFFFF, 1, d);
    apb(16'hFF00, 1, ~d);
    apb(16'hFFFF, 0, 0);
    chk(rd, d & 32'hFF);
    apb(`MPI_EXT_ADDR, 1, 32'h0ABC);
    apb(`MPI_EXT_DATA, 1, d);
    apb(`MPI_EXT_CTRL, 1, 1);
    bus_idle();
    apb(`MPI_EXT_DATA, 1, ~d);
    apb(`MPI_EXT_CTRL, 1, 3);
    bus_idle();
    apb(`MPI_EXT_DATA, 0, 0);
    chk(rd, d & 32'hFF);
    apb(`MPI_EXT_ADDR, 1, 32'h1000);
    apb(`MPI_EXT_CTRL, 1, 1);
    bus_idle();
    chk(rd[3:0], 4'b0010);
    mem_size_pins <= 2'b01;
    apb(`MPI_EXT_CTRL, 1, 1);
    bus_idle();
    chk(rd[3:0], 4'b0100);
    reset_n_pin <= 1'b0;
    repeat (4) @(posedge sys_clk);
    chk({port_a_drv, irq, pready}, {16'hFF00, 2'b00});
    reset_n_pin <= 1'b1;
    repeat (4) @(posedge sys_clk);
    apb(`MPI_IRQ_MASK, 0, 0);
    chk(rd, 0);
    stop_test();
  end
endmodule
